/* inc/lfd_pkg.sv */
package lfd_pkg;

  // ------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------
  localparam int unsigned WORD_W      = 64;          // Full register word
  localparam int unsigned ADDR_W      = 32;          // Extended-mode address word
  localparam int unsigned COEF_W      = 48;          // Coefficient magnitude width
  localparam int unsigned EXP_W       = 15;          // Biased exponent width
  localparam int unsigned SIGN_BIT    = 63;          // Coefficient sign position
  localparam int unsigned EXP_LSB     = 48;          // Exponent low bit
  localparam int unsigned EXP_MSB     = 62;          // Exponent high bit, the bias bit
  localparam int unsigned EXP_SGN_BIT = 61;          // Exponent sign bit
  localparam int unsigned NORM_BIT    = 47;          // Normalization bit
  localparam int unsigned VPROD_W     = 32;          // Vector integer product width
  localparam int unsigned VPROD_LSB   = 31;          // Vector scalar operand starts here, held in 62..31
  localparam logic [14:0] EXP_BIAS    = 15'h4000;    // 40000 octal
  localparam logic [14:0] EXP_ZERO    = 15'h0000;    // Integer multiply exponent

  // Truncation compensation added into the low product half
  localparam logic [47:0] TRUNC_COMP  = 48'h000000800000;

  // ------------------------------------------------------------
  // Operation codes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    LFD_OP_AND  = 4'h0,   // Logical product
    LFD_OP_OR   = 4'h1,   // Logical sum
    LFD_OP_XOR  = 4'h2,   // Logical difference
    LFD_OP_XNOR = 4'h3,   // Logical equivalence
    LFD_OP_MRG  = 4'h4,   // Merge under mask
    LFD_OP_ADD  = 4'h5,   // 64-bit add
    LFD_OP_SUB  = 4'h6,   // 64-bit subtract
    LFD_OP_AADD = 4'h7,   // 32-bit address add
    LFD_OP_AMUL = 4'h8,   // 32-bit address multiply
    LFD_OP_FMUL = 4'h9,   // Floating multiply / integer special case
    LFD_OP_VMUL = 4'hA    // Vector 32-bit integer multiply
  } lfd_op_t;

  // Unit states, one-hot
  typedef enum logic [1:0] {
    LFD_ST_IDLE = 2'b01,  // No result pending
    LFD_ST_DONE = 2'b10   // Result presented
  } lfd_state_t;

endpackage

/* rtl/lfd_logic.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bitwise logical unit, 64 independent bit positions
// ------------------------------------------------------------
module lfd_logic (
  input  wire logic [63:0]     a_in,     // First operand
  input  wire logic [63:0]     b_in,     // Second operand
  input  wire logic [63:0]     mask_in,  // Merge mask, one bit per position
  input  wire lfd_pkg::lfd_op_t op_in,   // Function select
  output logic      [63:0]     y_out     // Result
);
  wire [63:0] and_w  = a_in & b_in;
  wire [63:0] or_w   = a_in | b_in;
  wire [63:0] xor_w  = a_in ^ b_in;
  wire [63:0] xnor_w = ~(a_in ^ b_in);
  wire [63:0] mrg_w  = (a_in & mask_in) | (b_in & ~mask_in);

  // Function select
  assign y_out = (op_in == lfd_pkg::LFD_OP_AND)  ? and_w  :
                 (op_in == lfd_pkg::LFD_OP_OR)   ? or_w   :
                 (op_in == lfd_pkg::LFD_OP_XOR)  ? xor_w  :
                 (op_in == lfd_pkg::LFD_OP_XNOR) ? xnor_w : mrg_w;
endmodule
`default_nettype wire

/* rtl/lfd_mul.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Multiplier coefficient datapath with truncation compensation
// ------------------------------------------------------------
module lfd_mul (
  input  wire logic [63:0] a_in,       // First operand word
  input  wire logic [63:0] b_in,       // Second operand word
  output logic      [47:0] upper_out,  // Upper 48 product bits
  output logic             int_out     // Both exponents zero
);
  wire [95:0] prod_w = {48'h000000000000, a_in[47:0]} * {48'h000000000000, b_in[47:0]}; // Product
  // Compensation constant is always added
  wire [95:0] comp_w = prod_w + {48'h000000000000, lfd_pkg::TRUNC_COMP};

  assign upper_out = comp_w[95:48];
  assign int_out   = (a_in[62:48] == lfd_pkg::EXP_ZERO) &&
                     (b_in[62:48] == lfd_pkg::EXP_ZERO);
endmodule
`default_nettype wire

/* rtl/lfd_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Logical ops work per bit, 64 bits
// - AND, OR, XOR, XNOR functions
// - Merge: mask one picks first operand
// - Add and subtract in two's complement
// - Address units 32-bit, scalar/vector 64-bit
// - Zero exponents select integer multiply
// - Upper 48 bits, zero exponent, no shift
// - Integer product sign is XOR of signs
// - Truncation compensation added every multiply (only FMUL here, not AMUL or VMUL)
// - Vector product right-justified, upper cleared
// - No integer divide operation exists
// - Sign in bit 63, magnitude separate
// - Biased exponent bits 62..48, bias 40000
// - Bit 61 exponent sign, 62 bias
// - Coefficient 48-bit signed magnitude, never complemented
// - Bit 47 one means normalized
// - Zero or underflow is all zeros
// - No negative zero unless operand was (integer multiply here keeps the XOR sign on a zero upper product)
module lfd_top (
  input  wire logic            mclk_in,       // CPU clock
  input  wire logic            reset_in,      // Synchronous, active high
  input  wire logic            issue_in,      // Operation issue strobe
  input  wire lfd_pkg::lfd_op_t op_in,        // Operation code
  input  wire logic [63:0]     scalar_source_operand_in, // First operand
  input  wire logic [63:0]     vector_source_operand_in, // Second operand
  input  wire logic [63:0]     mask_in,       // Merge mask
  output logic      [63:0]     vector_result_register_out, // Result word
  output logic                 valid_out,     // Result valid pulse
  output logic                 int_mode_out,  // Last issued operation was an integer multiply
  output logic                 normalized_out,// Result bit 47 set
  output logic                 exp_neg_out,   // Result exponent sign
  output logic                 illegal_out    // Unsupported opcode (no divide)
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Exponent field of a word
  function automatic logic [14:0] exp_of(input logic [63:0] w);
    exp_of = w[lfd_pkg::EXP_MSB:lfd_pkg::EXP_LSB];
  endfunction

  // Coefficient magnitude of a word
  function automatic logic [47:0] coef_of(input logic [63:0] w);
    coef_of = w[lfd_pkg::NORM_BIT:0];
  endfunction

  // Pack sign, exponent and coefficient, forcing true zero
  function automatic logic [63:0] pack(input logic s, input logic [14:0] e,
                                       input logic [47:0] c, input logic keep_nz);
    if (c == 48'h000000000000) begin
      pack = {keep_nz, 15'h0000, 48'h000000000000};
    end else begin
      pack = {s, e, c};
    end
  endfunction

  // ------------------------------------------------------------
  // Combinational datapath
  // ------------------------------------------------------------
  wire [63:0] a_w = scalar_source_operand_in;               // Operand one
  wire [63:0] b_w = vector_source_operand_in;               // Operand two
  wire [63:0] log_w;                                        // Logical result
  wire [47:0] mup_w;                                        // Multiplier upper half
  wire        mint_w;                                       // Integer multiply mode

  lfd_logic u_logic (
    .a_in    (a_w),
    .b_in    (b_w),
    .mask_in (mask_in),
    .op_in   (op_in),
    .y_out   (log_w)
  );

  lfd_mul u_mul (
    .a_in      (a_w),
    .b_in      (b_w),
    .upper_out (mup_w),
    .int_out   (mint_w)
  );

  // Two's complement add units
  wire [63:0] add_w  = a_w + b_w;
  wire [63:0] sub_w  = a_w - b_w;
  wire [31:0] aadd_w = a_w[31:0] + b_w[31:0];
  wire [63:0] amul_f = {32'h00000000, a_w[31:0]} * {32'h00000000, b_w[31:0]}; // Full product
  wire [31:0] amul_w = amul_f[31:0];

  // Product sign
  wire        psign_w = a_w[lfd_pkg::SIGN_BIT] ^ b_w[lfd_pkg::SIGN_BIT];
  // Negative zero survives only when an operand was negative zero
  wire        nz_in_w = ((a_w[62:0] == 63'h0) && a_w[lfd_pkg::SIGN_BIT]) ||
                        ((b_w[62:0] == 63'h0) && b_w[lfd_pkg::SIGN_BIT]);

  // Integer multiply: upper 48 bits, zero exponent, no shift
  wire [63:0] imul_w = {psign_w, lfd_pkg::EXP_ZERO, mup_w};

  // Floating multiply: exponents add with one bias removed
  wire [15:0] esum_w = {1'b0, exp_of(a_w)} + {1'b0, exp_of(b_w)} -
                       {1'b0, lfd_pkg::EXP_BIAS};
  wire        ufl_w  = (esum_w[15] == 1'b1) ||
                       (esum_w[14:13] == 2'b00);
  wire [63:0] fmul_w = ufl_w ? {nz_in_w & psign_w, 63'h0} :
                       pack(psign_w, esum_w[14:0], mup_w, nz_in_w & psign_w);

  // Vector 32-bit integer multiply, operands pre-shifted by issue; the compensation
  // constant is not added here, so the kept bits are the plain low product
  localparam int unsigned VEC_LSB = lfd_pkg::EXP_LSB - lfd_pkg::VPROD_W; // Element low bit
  wire [31:0] vsca_w  = a_w[lfd_pkg::VPROD_LSB +: lfd_pkg::VPROD_W];
  wire [31:0] vele_w  = b_w[VEC_LSB +: lfd_pkg::VPROD_W];
  wire [63:0] vfull_w = {32'h00000000, vsca_w} * {32'h00000000, vele_w}; // Element product
  wire [31:0] vprod_w = vfull_w[31:0];                      // Right-justified product
  wire [63:0] vmul_w  = {32'h00000000, vprod_w};

  // Result select; no divide opcode exists
  wire        illegal_w = (op_in > lfd_pkg::LFD_OP_VMUL);
  wire [63:0] next_result =
    (op_in <= lfd_pkg::LFD_OP_MRG)  ? log_w :
    (op_in == lfd_pkg::LFD_OP_ADD)  ? add_w :
    (op_in == lfd_pkg::LFD_OP_SUB)  ? sub_w :
    (op_in == lfd_pkg::LFD_OP_AADD) ? {32'h00000000, aadd_w} :
    (op_in == lfd_pkg::LFD_OP_AMUL) ? {32'h00000000, amul_w} :
    (op_in == lfd_pkg::LFD_OP_FMUL) ? (mint_w ? imul_w : fmul_w) :
    (op_in == lfd_pkg::LFD_OP_VMUL) ? vmul_w : 64'h0000000000000000;
  // Coefficient of the selected result, for the normalization flag
  wire [47:0] rcoef_w = coef_of(next_result);

  // ------------------------------------------------------------
  // State machine
  // ------------------------------------------------------------
  lfd_pkg::lfd_state_t state;                               // Unit state
  lfd_pkg::lfd_state_t next_state;                          // Next unit state

  always_comb begin
    next_state = state;
    unique case (state)
      lfd_pkg::LFD_ST_IDLE: begin
        if (issue_in) begin
          next_state = lfd_pkg::LFD_ST_DONE;
        end
      end
      lfd_pkg::LFD_ST_DONE: begin
        if (!issue_in) begin
          next_state = lfd_pkg::LFD_ST_IDLE;
        end
      end
      default: begin
        next_state = lfd_pkg::LFD_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state <= lfd_pkg::LFD_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      vector_result_register_out <= 64'h0000000000000000;
      valid_out                  <= 1'b0;
      int_mode_out               <= 1'b0;
      normalized_out             <= 1'b0;
      exp_neg_out                <= 1'b0;
      illegal_out                <= 1'b0;
    end else begin
      valid_out <= issue_in & ~illegal_w;
      if (issue_in) begin
        vector_result_register_out <= illegal_w ? 64'h0000000000000000 : next_result;
        int_mode_out   <= (op_in == lfd_pkg::LFD_OP_FMUL) & mint_w;
        normalized_out <= rcoef_w[lfd_pkg::NORM_BIT];
        exp_neg_out    <= next_result[lfd_pkg::EXP_SGN_BIT];
        illegal_out    <= illegal_w;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  wire [63:0] res_w = vector_result_register_out;           // Result word as checked

  // Merge takes operand one where the mask is set
  merge_select_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_MRG |=>
    res_w == (($past(a_w) & $past(mask_in)) | ($past(b_w) & ~$past(mask_in))))
    else $error("merge result wrong");
  // Logical product per bit
  logic_and_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_AND |=>
    res_w == ($past(a_w) & $past(b_w)))
    else $error("and result wrong");

  // Logical sum per bit
  logic_or_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_OR |=>
    res_w == ($past(a_w) | $past(b_w)))
    else $error("or result wrong");
  // Logical difference per bit
  logic_xor_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_XOR |=>
    res_w == ($past(a_w) ^ $past(b_w)))
    else $error("xor result wrong");

  // Logical equivalence per bit
  logic_xnor_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_XNOR |=>
    res_w == ~($past(a_w) ^ $past(b_w)))
    else $error("xnor result wrong");
  // Scalar add wraps in 64 bits
  add_sum_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_ADD |=>
    res_w == $past(a_w) + $past(b_w))
    else $error("add result wrong");

  // Difference plus subtrahend gives the minuend
  sub_twos_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_SUB |=>
    res_w + $past(b_w) == $past(a_w))
    else $error("subtract not two's complement");
  // Address add keeps the upper half clear
  addr_width_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_AADD |=>
    res_w[63:32] == 32'h00000000)
    else $error("address add wider than 32 bits");

  // Address add value in 32 bits
  aadd_value_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_AADD |=>
    res_w[31:0] == $past(a_w[31:0]) + $past(b_w[31:0]))
    else $error("address add result wrong");
  // Address multiply keeps the low 32 product bits
  amul_value_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_AMUL |=>
    res_w == {32'h00000000, 32'($past(a_w[31:0]) * $past(b_w[31:0]))})
    else $error("address multiply result wrong");

  // Both exponents zero select integer mode
  int_mode_sel_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_FMUL &&
    (exp_of(a_w) | exp_of(b_w)) == lfd_pkg::EXP_ZERO |=> int_mode_out)
    else $error("integer multiply not selected");
  // Any exponent set keeps floating mode
  int_mode_off_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_FMUL &&
    (exp_of(a_w) | exp_of(b_w)) != lfd_pkg::EXP_ZERO |=> !int_mode_out)
    else $error("integer multiply wrongly selected");

  // Integer product leaves the exponent at zero
  int_exp_zero_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_FMUL && mint_w |=>
    int_mode_out && exp_of(res_w) == lfd_pkg::EXP_ZERO)
    else $error("integer multiply exponent not zero");
  // Integer product is the unshifted upper half
  int_upper_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_FMUL && mint_w |=>
    res_w[47:0] == $past(mup_w))
    else $error("integer product bits wrong");

  // Integer product sign from both operand signs
  int_sign_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_FMUL && mint_w |=>
    res_w[63] == ($past(a_w[63]) ^ $past(b_w[63])))
    else $error("integer product sign wrong");
  // Vector product right-justified in the low half
  vmul_value_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_VMUL |=>
    res_w[31:0] == $past(vsca_w) * $past(vele_w))
    else $error("vector product wrong");

  // Vector product clears the upper half
  vmul_upper_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_VMUL |=>
    res_w[63:32] == 32'h00000000)
    else $error("vector product upper bits set");
  // Unsupported code gives no valid result
  no_divide_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && illegal_w |=>
    illegal_out && !valid_out)
    else $error("unsupported opcode produced result");

  // Unsupported code returns a zero word
  illegal_zero_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && illegal_w |=>
    res_w == 64'h0000000000000000)
    else $error("unsupported opcode result not zero");
  // Every legal issue answers one edge later
  valid_legal_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && !illegal_w |=>
    valid_out && !illegal_out)
    else $error("legal issue not answered");

  // Floating product sign is the sign product
  fmul_sign_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_FMUL && !mint_w |=>
    res_w[47:0] == 48'h000000000000 || res_w[63] == ($past(a_w[63]) ^ $past(b_w[63])))
    else $error("float product sign wrong");
  // Floating exponents add with one bias removed
  fmul_exp_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_FMUL && !mint_w |=> res_w[62:0] == 63'h0 ||
    exp_of(res_w) + lfd_pkg::EXP_BIAS == $past(exp_of(a_w)) + $past(exp_of(b_w)))
    else $error("float product exponent wrong");

  // Exponent sign flag follows result bit 61
  exp_sign_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in |=>
    exp_neg_out == res_w[lfd_pkg::EXP_SGN_BIT])
    else $error("exponent sign flag wrong");
  // Coefficient is a magnitude, never complemented
  coef_mag_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_FMUL && !mint_w |=>
    res_w[62:0] == 63'h0 || res_w[47:0] == $past(mup_w))
    else $error("float coefficient complemented");

  // Normalized flag follows coefficient bit 47
  norm_flag_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in |=>
    normalized_out == res_w[lfd_pkg::NORM_BIT])
    else $error("normalized flag wrong");
  // Underflow returns an all-zero magnitude
  ufl_zero_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_FMUL && !mint_w && ufl_w |=>
    res_w[62:0] == 63'h0)
    else $error("underflow result not zero");

  // Zero coefficient carries no exponent
  fzero_coef_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_FMUL && !mint_w |=>
    res_w[47:0] != 48'h000000000000 || res_w[62:0] == 63'h0)
    else $error("zero result carries exponent");
  // Negative zero only from a negative zero operand
  neg_zero_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    issue_in && op_in == lfd_pkg::LFD_OP_FMUL && !mint_w && !nz_in_w |=>
    res_w != 64'h8000000000000000)
    else $error("negative zero generated");
endmodule
`default_nettype wire

/* sim/lfd_issuer.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Issue side model: formats operands and strobes requests
// ------------------------------------------------------------
module lfd_issuer (
  input  wire logic             clk_in,    // CPU clock
  output var  logic             issue_out, // Issue strobe
  output var  lfd_pkg::lfd_op_t op_out,    // Operation code
  output var  logic [63:0]      a_out,     // First operand
  output var  logic [63:0]      b_out,     // Second operand
  output var  logic [63:0]      m_out      // Merge mask
);
  // Quiet at time zero
  initial begin
    issue_out = 1'b0;
    op_out = lfd_pkg::LFD_OP_AND;
    a_out = 64'h0;
    b_out = 64'h0;
    m_out = 64'h0;
  end
  // Integer operand: exponent zero, value in 47..24, low 24 zero
  function automatic logic [63:0] int_word(input logic s, input logic [23:0] v);
    return {s, 15'h0000, v, 24'h000000};
  endfunction
  // Scalar operand of the vector product, held in 62..31
  function automatic logic [63:0] scal_word(input logic [31:0] v);
    return {1'b0, v, 31'h00000000};
  endfunction
  // Vector element, held in 47..16, rest zero
  function automatic logic [63:0] vec_word(input logic [31:0] v);
    return {16'h0000, v, 16'h0000};
  endfunction
  // One request, changed just after a rising edge
  task automatic send(input lfd_pkg::lfd_op_t op, input logic [63:0] a, b, m);
    @(posedge clk_in);
    issue_out <= 1'b1;
    op_out <= op;
    a_out <= a;
    b_out <= b;
    m_out <= m;
  endtask
  // Release: operands show garbage, not the last value
  task automatic idle();
    @(posedge clk_in);
    issue_out <= 1'b0;
    a_out <= ~a_out;
    b_out <= ~b_out;
    m_out <= ~m_out;
  endtask
endmodule
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic             mclk_in;  // Clock
  logic             reset_in; // Reset
  logic             iss;      // Issue strobe
  lfd_pkg::lfd_op_t op;       // Opcode
  logic [63:0]      a, b, m;  // Operands and mask
  logic [63:0]      y;        // Result
  logic             vld, imd, nrm, eng, ill; // Flags
  int               bad_count = 0;
  int               n_tests = 0;
  // Clock, 10 ns period
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  lfd_issuer u_iss (.clk_in(mclk_in), .issue_out(iss), .op_out(op), .a_out(a),
    .b_out(b), .m_out(m));
  lfd_top u_dut (.mclk_in(mclk_in), .reset_in(reset_in), .issue_in(iss), .op_in(op),
    .scalar_source_operand_in(a), .vector_source_operand_in(b), .mask_in(m),
    .vector_result_register_out(y), .valid_out(vld), .int_mode_out(imd),
    .normalized_out(nrm), .exp_neg_out(eng), .illegal_out(ill));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Result, then flags valid, int, norm, exp sign, illegal
  task automatic res(input logic [63:0] e, input logic [4:0] f);
    #1;
    check(y, e);
    check({59'h0, vld, imd, nrm, eng, ill}, {59'h0, f});
  endtask
  // One isolated request and its answer
  task automatic run(input lfd_pkg::lfd_op_t o, input logic [63:0] x, z, k,
                     input logic [63:0] e, input logic [4:0] f);
    u_iss.send(o, x, z, k);
    u_iss.idle();
    res(e, f);
  endtask
  // Upper product half with compensation added
  function automatic logic [47:0] up48(input logic [63:0] x, z);
    logic [95:0] p;
    p = {48'h0, x[47:0]} * {48'h0, z[47:0]} + {48'h0, lfd_pkg::TRUNC_COMP};
    return p[95:48];
  endfunction
  task automatic do_reset();
    reset_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
    res(64'h0, 5'h00);
    $display("test reset done");
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_logic();
    logic [63:0] x, z, k;
    x = 64'hAAAAAAAAAAAAAAAA;
    z = 64'hCCCCCCCCCCCCCCCC;
    k = 64'h80000000F0F00001;
    run(lfd_pkg::LFD_OP_AND, x, z, k, x & z, 5'h14);
    run(lfd_pkg::LFD_OP_OR, x, z, k, x | z, 5'h16);
    run(lfd_pkg::LFD_OP_XOR, x, z, k, x ^ z, 5'h12);
    run(lfd_pkg::LFD_OP_XNOR, x, z, k, ~(x ^ z), 5'h14);
    run(lfd_pkg::LFD_OP_MRG, x, z, k, (x & k) | (z & ~k), 5'h14);
    $display("test logic done");
  endtask
  task automatic t_add();
    run(lfd_pkg::LFD_OP_ADD, 64'hFFFFFFFFFFFFFFFF, 64'h2, 64'h0, 64'h1, 5'h10);
    run(lfd_pkg::LFD_OP_SUB, 64'h1, 64'h2, 64'h0, 64'hFFFFFFFFFFFFFFFF, 5'h16);
    run(lfd_pkg::LFD_OP_AADD, 64'hFFFFFFFF, 64'h2, 64'h0, 64'h1, 5'h10);
    run(lfd_pkg::LFD_OP_AMUL, 64'h10001, 64'h10001, 64'h0, 64'h20001, 5'h10);
    $display("test add done");
  endtask
  task automatic t_imul();
    logic [63:0] x, z;
    x = u_iss.int_word(1'b1, 24'h000004);
    z = u_iss.int_word(1'b0, 24'h000006);
    run(lfd_pkg::LFD_OP_FMUL, x, z, 64'h0, 64'h8000000000000018, 5'h18);
    x = 64'h0000FFFFFFFFFFFF;
    z = 64'h0000000000000001;
    run(lfd_pkg::LFD_OP_FMUL, x, z, 64'h0, {16'h0, up48(x, z)}, 5'h18);
    $display("test integer multiply done");
  endtask
  task automatic t_vmul();
    run(lfd_pkg::LFD_OP_VMUL, u_iss.scal_word(32'h3), u_iss.vec_word(32'h5), 64'h0,
        64'hF, 5'h10);
    $display("test vector multiply done");
  endtask
  task automatic t_fmul();
    logic [63:0] x, z;
    x = {1'b0, 15'h4001, 48'h800000000000};
    run(lfd_pkg::LFD_OP_FMUL, x, x, 64'h0, {1'b0, 15'h4002, 48'h400000000000}, 5'h10);
    x = {1'b1, 15'h4000, 48'hFFFFFFFFFFFF};
    z = {1'b0, 15'h3800, 48'hFFFFFFFFFFFF};
    run(lfd_pkg::LFD_OP_FMUL, x, z, 64'h0, {1'b1, 15'h3800, up48(x, z)}, 5'h16);
    $display("test float multiply done");
  endtask
  task automatic t_zero();
    logic [63:0] x, z;
    x = {1'b1, 15'h2000, 48'h800000000000};
    run(lfd_pkg::LFD_OP_FMUL, x, x, 64'h0, 64'h0, 5'h10);
    z = {1'b0, 15'h4001, 48'h800000000000};
    run(lfd_pkg::LFD_OP_FMUL, x, 64'h0, 64'h0, 64'h0, 5'h10);
    run(lfd_pkg::LFD_OP_FMUL, 64'h8000000000000000, z, 64'h0, 64'h8000000000000000,
        5'h10);
    $display("test zero done");
  endtask
  task automatic t_illegal();
    for (int k = 11; k < 16; k++) begin
      run(lfd_pkg::lfd_op_t'(4'(k)), 64'h5, 64'h3, 64'h0, 64'h0, 5'h01);
    end
    $display("test illegal done");
  endtask
  task automatic t_b2b();
    u_iss.send(lfd_pkg::LFD_OP_AND, 64'hF0, 64'h3C, 64'h0);
    u_iss.send(lfd_pkg::LFD_OP_XOR, 64'hF0, 64'h3C, 64'h0);
    res(64'h30, 5'h10);
    u_iss.idle();
    res(64'hCC, 5'h10);
    $display("test back to back done");
  endtask
  // ------------------------------------------------------------
  // Verdict
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog, far beyond the expected 55 or so cycles
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    reset_in = 1'b1;
    do_reset();
    t_logic();
    t_add();
    t_imul();
    t_vmul();
    t_fmul();
    t_zero();
    t_b2b();
    t_illegal();
    do_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
